// >>> btsc_addr_resolve.v
// Registered operand address resolver for the bit-test block.
// Assumes bank select and index base are stable when load is high.
`timescale 1ns/1ps
`include "btsc_defs.vh"

module btsc_addr_resolve #(
    parameter AW = 12
) (
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Operand request
    input wire load,
    input wire [7:0] fileAddr,
    input wire accessSel,
    input wire extEnable,
    input wire [3:0] bankSelect,
    input wire [AW-1:0] indexBase,
    // Resolved address
    output reg [AW-1:0] dataAddr
);

    reg [AW-1:0] next_dataAddr;

    // Address mode selection
    always @* begin
        next_dataAddr = dataAddr;
        if (load) begin
            if (accessSel) begin
                next_dataAddr = {bankSelect, fileAddr};
            end else if (extEnable && fileAddr <= `BTSC_IDX_LIMIT) begin
                next_dataAddr = indexBase + {{(AW-8){1'b0}}, fileAddr};
            end else if (fileAddr <= `BTSC_IDX_LIMIT) begin
                next_dataAddr = {`BTSC_ACC_LO_BANK, fileAddr};
            end else begin
                next_dataAddr = {`BTSC_ACC_HI_BANK, fileAddr};
            end
        end
    end

    // Held until the next load so the read port sees a steady address
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dataAddr <= `BTSC_ADDR_RST;
        end else begin
            dataAddr <= next_dataAddr;
        end
    end

endmodule

// >>> btsc_defs.vh
// Constants for the bit-test, skip-if-clear execution block.
// Assumes a 12-bit data address space and 16-bit program words.
`ifndef BTSC_DEFS_VH
`define BTSC_DEFS_VH

// Opcode field, top four bits of the word
`define BTSC_OPC_MSB 15
`define BTSC_OPC_LSB 12
`define BTSC_OPC_VAL 4'hb
// Bit index, access select and file address fields
`define BTSC_BIT_MSB 11
`define BTSC_BIT_LSB 9
`define BTSC_ACC_POS 8
`define BTSC_FILE_MSB 7
`define BTSC_FILE_LSB 0
// Highest file address read as an indexed literal offset
`define BTSC_IDX_LIMIT 8'h5f
// Upper part of the access bank, above 5Fh, sits in the top bank
`define BTSC_ACC_HI_BANK 4'hf
`define BTSC_ACC_LO_BANK 4'h0
// Cycle totals: no skip, skip, skip over a two-word instruction
`define BTSC_CYC_RUN 2'h1
`define BTSC_CYC_SKIP 2'h2
`define BTSC_CYC_SKIP2 2'h3
// Reset values
`define BTSC_ADDR_RST 12'h000
`define BTSC_CYC_RST 2'h0

`endif

// >>> btsc_exec.v
// Execution sequencer for the bit-test, skip-if-clear instruction.
// Assumes decode, bank select, index base and read data share clk;
// read data is valid in the same cycle as readReq.
// Function
// - Tested bit zero skips next instruction; bit one continues normally.
// - Skip discards the fetched word, runs a no-op; two cycles total.
// - Access select zero resolves the operand in the access bank.
// - Access select one uses bank select register for the bank.
// - Extended set with access zero treats low address as indexed offset.
// - Indexed offset applies only to addresses up to 5Fh.
// - Skipping a two-word instruction flushes both words; three cycles total.
`timescale 1ns/1ps
`include "btsc_defs.vh"

module btsc_exec #(
    parameter AW = 12
) (
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Decoded instruction
    input wire instValid,
    input wire [15:0] instWord,
    input wire nextTwoWord,
    // Core configuration
    input wire extEnable,
    input wire [3:0] bankSelect,
    input wire [AW-1:0] indexBase,
    // Data memory read port
    output wire [AW-1:0] dataAddr,
    output reg readReq,
    input wire [7:0] readData,
    // Pipeline control
    output reg busy,
    output reg flushFetch,
    output reg nopCycle,
    output reg skipTaken,
    output reg done,
    output reg [1:0] cycleCount,
    output reg statusWrite
);

    localparam ST_IDLE = 2'h0;
    localparam ST_TEST = 2'h1;
    localparam ST_NOP1 = 2'h2;
    localparam ST_NOP2 = 2'h3;

    reg [1:0] state;
    reg [1:0] next_state;
    reg [2:0] bitIndex;
    reg twoWord;
    reg next_readReq;
    reg next_busy;
    reg next_flushFetch;
    reg next_nopCycle;
    reg next_skipTaken;
    reg next_done;
    reg [1:0] next_cycleCount;

    wire isMatch;
    wire start;
    wire bitValue;
    wire [7:0] bitMask;
    wire [7:0] bitHit;
    genvar gi;

    // Opcode recognition, reused by start and the resolver load
    function opcodeMatch;
        input [15:0] word;
        begin
            opcodeMatch = (word[`BTSC_OPC_MSB:`BTSC_OPC_LSB] == `BTSC_OPC_VAL);
        end
    endfunction

    // One-hot decode of the 3-bit bit index
    function [7:0] oneHot;
        input [2:0] idx;
        begin
            oneHot = 8'h01 << idx;
        end
    endfunction

    // Cycle total of a finished instruction, shared by both closing arms
    // Keeps the run and skip totals in one place
    function [1:0] cycleTotal;
        input skip;
        input two;
        begin
            if (!skip) begin
                cycleTotal = `BTSC_CYC_RUN;
            end else if (two) begin
                cycleTotal = `BTSC_CYC_SKIP2;
            end else begin
                cycleTotal = `BTSC_CYC_SKIP;
            end
        end
    endfunction

    assign isMatch = opcodeMatch(instWord);
    assign start = instValid && isMatch && (state == ST_IDLE);

    // tested bit picked through a one-hot mask
    // Flat AND-OR instead of a variable index keeps the read path shallow
    assign bitMask = oneHot(bitIndex);
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : gBitTest
            assign bitHit[gi] = bitMask[gi] & readData[gi];
        end
    endgenerate
    assign bitValue = |bitHit;

    // Operand address is registered here and drives the read port
    btsc_addr_resolve #(
        .AW(AW)
    ) uResolve (
        .clk(clk),
        .rstn(rstn),
        .load(start),
        .fileAddr(instWord[`BTSC_FILE_MSB:`BTSC_FILE_LSB]),
        .accessSel(instWord[`BTSC_ACC_POS]),
        .extEnable(extEnable),
        .bankSelect(bankSelect),
        .indexBase(indexBase),
        .dataAddr(dataAddr)
    );

    // Capture bit index and the follower's word count at start
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bitIndex <= 3'h0;
            twoWord <= 1'b0;
        end else if (start) begin
            bitIndex <= instWord[`BTSC_BIT_MSB:`BTSC_BIT_LSB];
            twoWord <= nextTwoWord;
        end
    end

    // Sequencer next state and pipeline controls
    always @* begin
        next_state = state;
        next_readReq = 1'b0;
        next_busy = busy;
        next_flushFetch = 1'b0;
        next_nopCycle = 1'b0;
        next_skipTaken = 1'b0;
        next_done = 1'b0;
        next_cycleCount = cycleCount;
        case (state)
            ST_IDLE: begin
                if (start) begin
                    next_state = ST_TEST;
                    next_readReq = 1'b1;
                    next_busy = 1'b1;
                    next_cycleCount = `BTSC_CYC_RST;
                end
            end
            ST_TEST: begin
                if (!bitValue) begin
                    next_skipTaken = 1'b1;
                    next_flushFetch = 1'b1;
                    next_nopCycle = 1'b1;
                    next_state = twoWord ? ST_NOP2 : ST_NOP1;
                end else begin
                    next_state = ST_IDLE;
                    next_busy = 1'b0;
                    next_done = 1'b1;
                    next_cycleCount = cycleTotal(1'b0, twoWord);
                end
            end
            ST_NOP2: begin
                next_flushFetch = 1'b1;
                next_nopCycle = 1'b1;
                next_state = ST_NOP1;
            end
            ST_NOP1: begin
                // Last no-op cycle closes the instruction
                next_state = ST_IDLE;
                next_busy = 1'b0;
                next_done = 1'b1;
                next_cycleCount = cycleTotal(1'b1, twoWord);
            end
        endcase
    end

    // Sequencer state register
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // All controls come straight from flops
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            readReq <= 1'b0;
            busy <= 1'b0;
            flushFetch <= 1'b0;
            nopCycle <= 1'b0;
            skipTaken <= 1'b0;
            done <= 1'b0;
            cycleCount <= `BTSC_CYC_RST;
            statusWrite <= 1'b0;
        end else begin
            readReq <= next_readReq;
            busy <= next_busy;
            flushFetch <= next_flushFetch;
            nopCycle <= next_nopCycle;
            skipTaken <= next_skipTaken;
            done <= next_done;
            cycleCount <= next_cycleCount;
            statusWrite <= 1'b0;
        end
    end

endmodule

// >>> btsc_exec_monitor.sv
// Assertion checker for the bit-test skip sequencer.
// Sees only the sequencer ports; bound from the bench top.
`timescale 1ns/1ps
module btsc_exec_monitor #(parameter AW = 12) (
    // Control and configuration
    input wire clk, rstn, instValid, nextTwoWord, extEnable,
    input wire [15:0] instWord,
    input wire [3:0] bankSelect,
    input wire [AW-1:0] indexBase, dataAddr,
    // Read port and pipeline
    input wire readReq, busy, flushFetch, nopCycle, skipTaken, done, statusWrite,
    input wire [7:0] readData,
    input wire [1:0] cycleCount
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // Accepted start and the bit index it carries
    wire start = instValid && instWord[15:12] == 4'hb && !busy;
    wire [7:0] f = instWord[7:0];
    reg [2:0] bitSel;
    reg twoWord;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bitSel <= 3'h0;
            twoWord <= 1'b0;
        end else if (start) begin
            bitSel <= instWord[11:9];
            twoWord <= nextTwoWord;
        end
    end
    // Decision inputs, valid only while the read is out
    wire hit = readReq && readData[bitSel];
    wire miss = readReq && !readData[bitSel];
    sequence s_skip; skipTaken && flushFetch && nopCycle && !done; endsequence
    sequence s_flush; flushFetch && nopCycle && !done; endsequence
    a_read_issue: assert property (start |=> readReq && busy && cycleCount == 2'h0)
        else $error("no read after start");
    a_bank_addr: assert property (start && instWord[8] |=> dataAddr == {$past(bankSelect), $past(f)})
        else $error("banked address wrong");
    a_access_addr: assert property (start && !instWord[8] && !(extEnable && f <= 8'h5f)
        |=> dataAddr == {($past(f) <= 8'h5f) ? 4'h0 : 4'hf, $past(f)})
        else $error("access bank address wrong");
    a_index_addr: assert property (start && !instWord[8] && extEnable && f <= 8'h5f
        |=> dataAddr == $past(indexBase) + $past(f))
        else $error("indexed address wrong");
    a_no_skip: assert property (hit |=> done && !skipTaken && !flushFetch && cycleCount == 2'h1)
        else $error("set bit did not finish in one cycle");
    a_skip_one: assert property (miss && !twoWord |=> s_skip ##1 done && cycleCount == 2'h2)
        else $error("single skip sequence wrong");
    a_skip_two: assert property (miss && twoWord |=> s_skip ##1 s_flush ##1 done && cycleCount == 2'h3)
        else $error("double skip sequence wrong");
    a_status_kept: assert property (statusWrite == 1'b0)
        else $error("status written");
endmodule

// >>> btsc_exec_tb.sv
// Self-checking bench for the bit-test skip sequencer.
// Drives every sequencer input directly; no far-side model.
`timescale 1ns/1ps
`define CHK(n, e, s) begin nTests++; if ((s) !== (e)) begin errors++; $display("ERROR %s exp %h got %h", n, e, s); end end
module btsc_exec_tb;
    reg clk = 0, rstn = 0, instValid = 0, nextTwoWord = 0, extEnable = 0;
    reg [15:0] instWord = 16'h0;
    reg [3:0] bankSelect = 4'h0;
    reg [11:0] indexBase = 12'h0;
    reg [7:0] readData = 8'h0;
    wire [11:0] dataAddr;
    wire readReq, busy, flushFetch, nopCycle, skipTaken, done, statusWrite;
    wire [1:0] cycleCount;
    integer errors = 0, nTests = 0, cyc = 0, i;
    btsc_exec #(.AW(12)) DUT (
        .clk(clk), .rstn(rstn), .instValid(instValid), .instWord(instWord), .nextTwoWord(nextTwoWord),
        .extEnable(extEnable), .bankSelect(bankSelect), .indexBase(indexBase), .dataAddr(dataAddr),
        .readReq(readReq), .readData(readData), .busy(busy), .flushFetch(flushFetch), .nopCycle(nopCycle),
        .skipTaken(skipTaken), .done(done), .cycleCount(cycleCount), .statusWrite(statusWrite)
    );
    always #10 clk = ~clk;
    function [11:0] expAddr(input [15:0] w, input e, input [3:0] b, input [11:0] ib);
        if (w[8]) expAddr = {b, w[7:0]};
        else if (w[7:0] > 8'h5f) expAddr = {4'hf, w[7:0]};
        else expAddr = e ? ib + w[7:0] : {4'h0, w[7:0]};
    endfunction
    function [1:0] expCyc(input [15:0] w, input t, input [7:0] d);
        expCyc = d[w[11:9]] ? 2'h1 : (t ? 2'h3 : 2'h2);
    endfunction
    // One instruction; returns in its done cycle so the next is back to back
    task run(input [15:0] w, input t, input e, input [3:0] b, input [11:0] ib, input [7:0] d);
        integer n, fl, sk, np, rq;
        begin
            // A call made in the done cycle presents at once
            if (!done)
                @(posedge clk) #1;
            {instValid, instWord, nextTwoWord, extEnable, bankSelect, indexBase} = {1'b1, w, t, e, b, ib};
            @(posedge clk) #1;
            instValid = 0;
            readData = d;
            `CHK("readReq", 1'b1, readReq)
            `CHK("dataAddr", expAddr(w, e, b, ib), dataAddr)
            n = 1;
            fl = 0;
            sk = 0;
            np = 0;
            rq = 0;
            // Bounded wait; stale read data is scrambled each cycle
            while (!done && n < 6) begin
                @(posedge clk) #1;
                readData = $urandom;
                // Matching words offered while busy must be refused
                if (!done) begin
                    instValid = 1'b1;
                    instWord = {4'hb, 12'($urandom)};
                end
                n = n + 1;
                fl = fl + flushFetch;
                sk = sk + skipTaken;
                np = np + nopCycle;
                rq = rq + readReq;
            end
            `CHK("cycleCount", expCyc(w, t, d), cycleCount)
            `CHK("doneAt", {1'b0, expCyc(w, t, d)} + 3'h1, n[2:0])
            `CHK("flushes", expCyc(w, t, d) - 2'h1, fl[1:0])
            `CHK("skipTaken", {1'b0, expCyc(w, t, d) != 2'h1}, sk[1:0])
            `CHK("nopCycles", expCyc(w, t, d) - 2'h1, np[1:0])
            `CHK("extraReads", 2'h0, rq[1:0])
            `CHK("busyAtDone", 1'b0, busy)
            `CHK("statusWrite", 1'b0, statusWrite)
        end
    endtask
    task summarize;
        begin
            $display("errors=%0d checks=%0d", errors, nTests);
            if (errors == 0 && nTests > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    // Hang guard, far above the expected run length
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc > 2000) begin
            errors = errors + 1;
            summarize;
        end
    end
    initial begin
        void'($urandom(21));
        repeat (20) @(posedge clk);
        #1 rstn = 1;
        // Corners: index limit both sides, banked two-word skip
        run(16'hb25f, 0, 1, 4'h3, 12'h7f0, 8'h00);
        run(16'hb260, 1, 1, 4'h3, 12'h7f0, 8'hff);
        run(16'hbf9a, 1, 0, 4'h5, 12'h000, 8'h7f);
        run(16'hb044, 0, 0, 4'h5, 12'h000, 8'h01);
        for (i = 0; i < 60; i = i + 1)
            run({4'hb, 12'($urandom)}, $urandom, $urandom, $urandom, $urandom, $urandom);
        // Foreign opcode in the done cycle must be ignored
        {instValid, instWord} = {1'b1, 16'ha25f};
        @(posedge clk) #1;
        instValid = 0;
        `CHK("refused", 1'b0, readReq)
        summarize;
    end
endmodule
bind btsc_exec btsc_exec_monitor #(.AW(AW)) mon (
    .clk(clk), .rstn(rstn), .instValid(instValid), .nextTwoWord(nextTwoWord), .extEnable(extEnable),
    .instWord(instWord), .bankSelect(bankSelect), .indexBase(indexBase), .dataAddr(dataAddr),
    .readReq(readReq), .busy(busy), .flushFetch(flushFetch), .nopCycle(nopCycle), .skipTaken(skipTaken),
    .done(done), .statusWrite(statusWrite), .readData(readData), .cycleCount(cycleCount)
);
